// ### status_pin_pkg.sv
package status_pin_pkg;

   // ----------------------------------------
   // register map, byte addressed
   // ----------------------------------------
   localparam logic [7:0] ADDR_PIN_SEL = 8'h88;
   localparam logic [7:0] ADDR_POLARITY = 8'h8a;
   localparam logic [7:0] ADDR_MASK = 8'h8c;
   localparam logic [7:0] ADDR_STICKY = 8'h90;
   localparam logic [7:0] ADDR_NOW = 8'h94;
   localparam logic [7:0] ADDR_SELECTED = 8'h96;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // ----------------------------------------
   // field layout
   // ----------------------------------------
   localparam int SEL_A_LSB = 0;
   localparam int SEL_B_LSB = 4;
   localparam int SEL_W = 4;
   localparam int POL_BIT = 0;
   localparam int FCV_BIT = 7;
   localparam int IDX_LSB = 4;
   localparam int IDX_W = 2;
   localparam int ALERT_COUNT = 8;
   localparam int INPUT_COUNT = 4;

   // alert bit order as seen in mask, sticky and momentary registers
   localparam int BIT_INPUT0 = 7;
   localparam int BIT_LOCK0 = 3;
   localparam int BIT_LOCK1 = 2;
   localparam int BIT_HOLD = 1;
   localparam int BIT_REF = 0;

   // ----------------------------------------
   // pin function codes
   // ----------------------------------------
   typedef enum logic [3:0] {
      FN_RESERVED0 = 4'b0000,
      FN_FORCE_HOLD = 4'b0001,
      FN_FORCE_MID = 4'b0010,
      FN_INPUT_SELECT = 4'b0111,
      FN_LOOP0_LOCK = 4'b1000,
      FN_LOOP1_LOCK = 4'b1001,
      FN_BOTH_LOCK = 4'b1010,
      FN_ACTIVITY_ALARM = 4'b1011,
      FN_HOLDOVER = 4'b1100,
      FN_INTERRUPT = 4'b1101,
      FN_RESERVED14 = 4'b1110,
      FN_SHOW_SELECTED = 4'b1111
   } pin_fn_t;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam pin_fn_t PIN_A_SEL_RESET = FN_ACTIVITY_ALARM;
   localparam pin_fn_t PIN_B_SEL_RESET = FN_BOTH_LOCK;
   localparam logic POL_RESET = 1'b0;
   localparam logic [7:0] MASK_RESET = 8'h00;

endpackage

// ### alert_latch_cell.sv
`timescale 1ns/1ps
`default_nettype none

// one sticky event latch with its mask gate
module alert_latch_cell (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic fault_i,
   input wire logic clear_i,
   input wire logic mask_i,
   output logic seen_o,
   output logic pending_o
);

   typedef struct packed {
      logic seen;
   } cell_state_t;

   cell_state_t state_reg;
   cell_state_t state_next;

   always_comb begin
      state_next = state_reg;
      if (ce_i) begin
         // set wins: a fault in the clearing cycle is kept
         if (fault_i) begin
            state_next.seen = 1'b1;
         end else if (clear_i) begin
            state_next.seen = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign seen_o = state_reg.seen;
   assign pending_o = state_reg.seen & mask_i;

endmodule

`default_nettype wire

// ### status_pin_alert_latch.sv
`timescale 1ns/1ps
`default_nettype none

module status_pin_alert_latch (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [7:0] cfg_wdata_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   output logic [7:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   input wire logic [3:0] input_active_now_i,
   input wire logic first_loop_lock_now_i,
   input wire logic second_loop_lock_now_i,
   input wire logic holdover_active_i,
   input wire logic reference_present_now_i,
   input wire logic [1:0] selected_input_index_i,
   input wire logic pin_a_i,
   output logic pin_a_o,
   output logic pin_a_oe_o,
   input wire logic pin_b_i,
   output logic pin_b_o,
   output logic pin_b_oe_o,
   output logic force_holdover_o,
   output logic force_mid_supply_o,
   output logic [1:0] input_select_o,
   output logic input_select_valid_o,
   output logic alert_irq_o
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      status_pin_pkg::pin_fn_t pin_a_sel;
      status_pin_pkg::pin_fn_t pin_b_sel;
      logic pol;
      logic [7:0] mask;
      logic a_sync1;
      logic a_sync2;
      logic b_sync1;
      logic b_sync2;
      logic pin_a_out;
      logic pin_a_oe;
      logic pin_b_out;
      logic pin_b_oe;
      logic force_hold;
      logic force_mid;
      logic [1:0] in_sel;
      logic in_sel_valid;
      logic irq;
      logic [7:0] rdata;
      logic rvalid;
   } state_t;

   localparam state_t STATE_RESET = '{
      pin_a_sel: status_pin_pkg::PIN_A_SEL_RESET,
      pin_b_sel: status_pin_pkg::PIN_B_SEL_RESET,
      pol: status_pin_pkg::POL_RESET,
      mask: status_pin_pkg::MASK_RESET,
      a_sync1: 1'b0,
      a_sync2: 1'b0,
      b_sync1: 1'b0,
      b_sync2: 1'b0,
      pin_a_out: 1'b0,
      pin_a_oe: 1'b0,
      pin_b_out: 1'b0,
      pin_b_oe: 1'b0,
      force_hold: 1'b0,
      force_mid: 1'b0,
      in_sel: 2'h0,
      in_sel_valid: 1'b0,
      irq: 1'b0,
      rdata: status_pin_pkg::RDATA_UNMAPPED,
      rvalid: 1'b0
   };

   state_t state_reg;
   state_t state_next;

   logic [7:0] fault_w;
   logic [7:0] momentary_w;
   logic [7:0] clear_w;
   logic [7:0] seen_w;
   logic [7:0] pending_w;
   logic irq_now_w;
   logic alarm_w;
   logic wr_sel_w;
   logic wr_pol_w;
   logic wr_mask_w;
   logic wr_sticky_w;

   // ----------------------------------------
   // alert sources and sticky latches
   // ----------------------------------------
   // momentary view: 1 means healthy for every source
   always_comb begin
      for (int i = 0; i < status_pin_pkg::INPUT_COUNT; i++) begin
         momentary_w[status_pin_pkg::BIT_INPUT0 - i] = input_active_now_i[i];
      end
      momentary_w[status_pin_pkg::BIT_LOCK0] = first_loop_lock_now_i;
      momentary_w[status_pin_pkg::BIT_LOCK1] = second_loop_lock_now_i;
      momentary_w[status_pin_pkg::BIT_HOLD] = ~holdover_active_i;
      momentary_w[status_pin_pkg::BIT_REF] = reference_present_now_i;
   end

   // a source is faulted whenever its momentary view is low
   assign fault_w = ~momentary_w;

   assign wr_sel_w = cfg_wr_i && (cfg_addr_i == status_pin_pkg::ADDR_PIN_SEL);
   assign wr_pol_w = cfg_wr_i && (cfg_addr_i == status_pin_pkg::ADDR_POLARITY);
   assign wr_mask_w = cfg_wr_i && (cfg_addr_i == status_pin_pkg::ADDR_MASK);
   assign wr_sticky_w = cfg_wr_i && (cfg_addr_i == status_pin_pkg::ADDR_STICKY);

   // write-one-to-clear, per bit
   assign clear_w = wr_sticky_w ? cfg_wdata_i : 8'h00;

   genvar g;
   generate
      for (g = 0; g < status_pin_pkg::ALERT_COUNT; g++) begin : gen_latch
         alert_latch_cell u_cell (
            .core_clk_i(core_clk_i),
            .reset_i(reset_i),
            .ce_i(ce_i),
            .fault_i(fault_w[g]),
            .clear_i(clear_w[g]),
            .mask_i(state_reg.mask[g]),
            .seen_o(seen_w[g]),
            .pending_o(pending_w[g])
         );
      end
   endgenerate

   assign irq_now_w = |pending_w;
   assign alarm_w = ~&input_active_now_i;

   // ----------------------------------------
   // pin output function
   // ----------------------------------------
   // returns {drive, level} before polarity
   function automatic logic [1:0] pin_drive(
      input status_pin_pkg::pin_fn_t fn,
      input logic lock0,
      input logic lock1,
      input logic alarm,
      input logic hold,
      input logic irq
   );
      logic [1:0] r;
      r = 2'b00;
      case (fn)
         status_pin_pkg::FN_LOOP0_LOCK: r = {1'b1, lock0};
         status_pin_pkg::FN_LOOP1_LOCK: r = {1'b1, lock1};
         status_pin_pkg::FN_BOTH_LOCK: r = {1'b1, lock0 & lock1};
         status_pin_pkg::FN_ACTIVITY_ALARM: r = {1'b1, alarm};
         status_pin_pkg::FN_HOLDOVER: r = {1'b1, hold};
         status_pin_pkg::FN_INTERRUPT: r = {1'b1, irq};
         default: r = 2'b00;
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [1:0] drv_a;
      logic [1:0] drv_b;
      logic a_overrides_b;
      drv_a = 2'b00;
      drv_b = 2'b00;
      a_overrides_b = 1'b0;
      state_next = state_reg;
      if (ce_i) begin
         // pins come from outside: two flops before any use
         state_next.a_sync1 = pin_a_i;
         state_next.a_sync2 = state_reg.a_sync1;
         state_next.b_sync1 = pin_b_i;
         state_next.b_sync2 = state_reg.b_sync1;

         if (wr_sel_w) begin
            state_next.pin_a_sel = status_pin_pkg::pin_fn_t'(
               cfg_wdata_i[status_pin_pkg::SEL_A_LSB +: status_pin_pkg::SEL_W]);
            state_next.pin_b_sel = status_pin_pkg::pin_fn_t'(
               cfg_wdata_i[status_pin_pkg::SEL_B_LSB +: status_pin_pkg::SEL_W]);
         end
         if (wr_pol_w) begin
            state_next.pol = cfg_wdata_i[status_pin_pkg::POL_BIT];
         end
         if (wr_mask_w) begin
            state_next.mask = cfg_wdata_i;
         end

         state_next.irq = irq_now_w;

         // pin A in a paired mode takes pin B over, whatever pin B holds
         a_overrides_b = (state_reg.pin_a_sel == status_pin_pkg::FN_INPUT_SELECT) ||
                         (state_reg.pin_a_sel == status_pin_pkg::FN_SHOW_SELECTED);

         drv_a = pin_drive(state_reg.pin_a_sel, first_loop_lock_now_i,
                           second_loop_lock_now_i, alarm_w, holdover_active_i, irq_now_w);
         drv_b = pin_drive(state_reg.pin_b_sel, first_loop_lock_now_i,
                           second_loop_lock_now_i, alarm_w, holdover_active_i, irq_now_w);

         if (state_reg.pin_a_sel == status_pin_pkg::FN_SHOW_SELECTED) begin
            drv_a = {1'b1, selected_input_index_i[0]};
            drv_b = {1'b1, selected_input_index_i[1]};
         end else if (state_reg.pin_a_sel == status_pin_pkg::FN_INPUT_SELECT) begin
            drv_b = 2'b00;
         end

         // polarity touches driven outputs only
         state_next.pin_a_oe = drv_a[1];
         state_next.pin_a_out = drv_a[1] & (drv_a[0] ^ state_reg.pol);
         state_next.pin_b_oe = drv_b[1];
         state_next.pin_b_out = drv_b[1] & (drv_b[0] ^ state_reg.pol);

         // pin input functions; pin B's reserved paired codes drive nothing
         state_next.force_hold =
            ((state_reg.pin_a_sel == status_pin_pkg::FN_FORCE_HOLD) && state_reg.a_sync2) ||
            (!a_overrides_b && (state_reg.pin_b_sel == status_pin_pkg::FN_FORCE_HOLD) &&
             state_reg.b_sync2);
         state_next.force_mid =
            ((state_reg.pin_a_sel == status_pin_pkg::FN_FORCE_MID) && state_reg.a_sync2) ||
            (!a_overrides_b && (state_reg.pin_b_sel == status_pin_pkg::FN_FORCE_MID) &&
             state_reg.b_sync2);
         state_next.in_sel_valid = (state_reg.pin_a_sel == status_pin_pkg::FN_INPUT_SELECT);
         if (state_reg.pin_a_sel == status_pin_pkg::FN_INPUT_SELECT) begin
            state_next.in_sel = {state_reg.b_sync2, state_reg.a_sync2};
         end

         // register reads, one cycle latency
         state_next.rvalid = cfg_rd_i;
         if (cfg_rd_i) begin
            case (cfg_addr_i)
               status_pin_pkg::ADDR_PIN_SEL: begin
                  state_next.rdata = {state_reg.pin_b_sel, state_reg.pin_a_sel};
               end
               status_pin_pkg::ADDR_POLARITY: begin
                  state_next.rdata = status_pin_pkg::RDATA_UNMAPPED;
                  state_next.rdata[status_pin_pkg::POL_BIT] = state_reg.pol;
               end
               status_pin_pkg::ADDR_MASK: begin
                  state_next.rdata = state_reg.mask;
               end
               status_pin_pkg::ADDR_STICKY: begin
                  state_next.rdata = ~seen_w;
               end
               status_pin_pkg::ADDR_NOW: begin
                  state_next.rdata = momentary_w;
               end
               status_pin_pkg::ADDR_SELECTED: begin
                  state_next.rdata = status_pin_pkg::RDATA_UNMAPPED;
                  state_next.rdata[status_pin_pkg::FCV_BIT] = state_reg.force_mid;
                  state_next.rdata[status_pin_pkg::IDX_LSB +: status_pin_pkg::IDX_W] =
                     selected_input_index_i;
               end
               default: begin
                  state_next.rdata = status_pin_pkg::RDATA_UNMAPPED;
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign cfg_rdata_o = state_reg.rdata;
   assign cfg_rvalid_o = state_reg.rvalid;
   assign pin_a_o = state_reg.pin_a_out;
   assign pin_a_oe_o = state_reg.pin_a_oe;
   assign pin_b_o = state_reg.pin_b_out;
   assign pin_b_oe_o = state_reg.pin_b_oe;
   assign force_holdover_o = state_reg.force_hold;
   assign force_mid_supply_o = state_reg.force_mid;
   assign input_select_o = state_reg.in_sel;
   assign input_select_valid_o = state_reg.in_sel_valid;
   assign alert_irq_o = state_reg.irq;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);

   sticky_set_wins_a: assert property (
      ce_i |=> ((seen_w & $past(fault_w)) == $past(fault_w)))
      else $error("fault did not latch in its sticky bit");

   sticky_clear_a: assert property (
      ce_i |=> ((seen_w & $past(clear_w) & ~$past(fault_w)) == 8'h00))
      else $error("write one did not clear a sticky bit");

   sticky_holds_a: assert property (
      ce_i |=> (($past(seen_w) & ~$past(clear_w) & ~seen_w) == 8'h00))
      else $error("sticky bit dropped without a clear");

   irq_follows_a: assert property (
      ce_i |=> (alert_irq_o == $past(|(seen_w & state_reg.mask))))
      else $error("interrupt does not match masked latches");

   mask_blocks_a: assert property (
      (ce_i && (state_reg.mask == 8'h00)) |=> !alert_irq_o)
      else $error("interrupt raised with all alerts masked");

   lock_pin_pol_a: assert property (
      (ce_i && (state_reg.pin_a_sel == status_pin_pkg::FN_LOOP0_LOCK))
      |=> (pin_a_oe_o && (pin_a_o == ($past(first_loop_lock_now_i) ^ $past(state_reg.pol)))))
      else $error("pin A lock output wrong");

   int_pin_b_a: assert property (
      (ce_i && (state_reg.pin_b_sel == status_pin_pkg::FN_INTERRUPT) &&
       (state_reg.pin_a_sel != status_pin_pkg::FN_SHOW_SELECTED) &&
       (state_reg.pin_a_sel != status_pin_pkg::FN_INPUT_SELECT))
      |=> (pin_b_oe_o && (pin_b_o == (alert_irq_o ^ $past(state_reg.pol)))))
      else $error("pin B interrupt output wrong");

   show_index_a: assert property (
      (ce_i && (state_reg.pin_a_sel == status_pin_pkg::FN_SHOW_SELECTED))
      |=> (pin_a_oe_o && pin_b_oe_o &&
           ({pin_b_o, pin_a_o} ==
            ($past(selected_input_index_i) ^ {2{$past(state_reg.pol)}}))))
      else $error("selected input not shown on pins");

   input_select_a: assert property (
      (ce_i && $past(ce_i) && $past(ce_i, 2) &&
       (state_reg.pin_a_sel == status_pin_pkg::FN_INPUT_SELECT))
      |=> (!pin_a_oe_o && !pin_b_oe_o && input_select_valid_o &&
           (input_select_o == {$past(pin_b_i, 3), $past(pin_a_i, 3)})))
      else $error("input select pins not taken through two flops");

   input_pin_quiet_a: assert property (
      (ce_i && ((state_reg.pin_a_sel == status_pin_pkg::FN_FORCE_HOLD) ||
                (state_reg.pin_a_sel == status_pin_pkg::FN_FORCE_MID)))
      |=> !pin_a_oe_o)
      else $error("pin A driven while an input");

   read_sticky_a: assert property (
      (ce_i && cfg_rd_i && (cfg_addr_i == status_pin_pkg::ADDR_STICKY))
      |=> (cfg_rvalid_o && (cfg_rdata_o == ~$past(seen_w))))
      else $error("sticky read returns wrong value");

   read_index_a: assert property (
      (ce_i && cfg_rd_i && (cfg_addr_i == status_pin_pkg::ADDR_SELECTED))
      |=> (cfg_rdata_o[status_pin_pkg::IDX_LSB +: status_pin_pkg::IDX_W] ==
           $past(selected_input_index_i)))
      else $error("selected index read wrong");

   irq_raised_c: cover property (ce_i && !alert_irq_o ##1 alert_irq_o);
   int_pin_c: cover property (pin_a_oe_o && (state_reg.pin_a_sel == status_pin_pkg::FN_INTERRUPT)
                              && alert_irq_o);
   clear_c: cover property ((ce_i && (|(clear_w & seen_w))) ##1 (seen_w == 8'h00));
   in_sel_c: cover property (input_select_valid_o && (input_select_o == 2'h3));

endmodule

`default_nettype wire

// ### status_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the two status pins
module status_host_model (
   input wire logic core_clk_i,
   input wire logic pin_a_o,
   input wire logic pin_a_oe_o,
   input wire logic pin_b_o,
   input wire logic pin_b_oe_o,
   input wire logic drive_en_i,
   input wire logic drive_a_i,
   input wire logic drive_b_i,
   output logic pin_a_i,
   output logic pin_b_i
);
   logic last_a = 1'b0;
   logic last_b = 1'b0;
   always_ff @(posedge core_clk_i) begin
      last_a <= pin_a_i;
      last_b <= pin_b_i;
   end
   // a released line toggles each cycle so a stale level cannot pass as data
   always_comb begin
      pin_a_i = pin_a_oe_o ? pin_a_o : (drive_en_i ? drive_a_i : ~last_a);
      pin_b_i = pin_b_oe_o ? pin_b_o : (drive_en_i ? drive_b_i : ~last_b);
   end
endmodule
`default_nettype wire

// ### tb_status_pin_alert_latch.sv
`timescale 1ns/1ps
`default_nettype none

module tb_status_pin_alert_latch;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic [7:0] rdata;
   logic rvalid, pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, f_hold, f_mid, sel_v, irq;
   logic [1:0] sel;
   logic [3:0] act = 4'hf;
   logic lk0 = 1'b1;
   logic lk1 = 1'b1;
   logic hold = 1'b0;
   logic refp = 1'b1;
   logic [1:0] idx = 2'h0;
   logic ha = 1'b0;
   logic hb = 1'b0;
   logic hen = 1'b0;
   logic ce = 1'b1;
   logic [7:0] code [5] = '{8'h8b, 8'h9b, 8'hab, 8'hbb, 8'hcb};
   logic expv [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   int bad_count = 0;
   int checks = 0;

   always #12.5 core_clk_i = ~core_clk_i;

   status_pin_alert_latch i_status_pin_alert_latch (.core_clk_i(core_clk_i),
      .reset_i(reset_i), .ce_i(ce), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
      .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
      .input_active_now_i(act), .first_loop_lock_now_i(lk0),
      .second_loop_lock_now_i(lk1), .holdover_active_i(hold),
      .reference_present_now_i(refp), .selected_input_index_i(idx),
      .pin_a_i(pa_i), .pin_a_o(pa_o), .pin_a_oe_o(pa_oe), .pin_b_i(pb_i),
      .pin_b_o(pb_o), .pin_b_oe_o(pb_oe), .force_holdover_o(f_hold),
      .force_mid_supply_o(f_mid), .input_select_o(sel),
      .input_select_valid_o(sel_v), .alert_irq_o(irq));

   status_host_model i_status_host_model (.core_clk_i(core_clk_i), .pin_a_o(pa_o),
      .pin_a_oe_o(pa_oe), .pin_b_o(pb_o), .pin_b_oe_o(pb_oe), .drive_en_i(hen),
      .drive_a_i(ha), .drive_b_i(hb), .pin_a_i(pa_i), .pin_b_i(pb_i));

   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   task check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task check1(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask

   task step(input int n);
      repeat (n) @(posedge core_clk_i);
      #2;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      #2 cfg_wr = 1'b1;
      addr = a;
      wdata = d;
      @(posedge core_clk_i);
      #2 cfg_wr = 1'b0;
   endtask

   task rd_check(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge core_clk_i);
      #2 cfg_rd = 1'b1;
      addr = a;
      @(posedge core_clk_i);
      #1 check1("rvalid", 1'b1, rvalid);
      check8(name, exp, rdata);
      #1 cfg_rd = 1'b0;
   endtask

   // alert bit order: 7..4 inputs 0..3, then lock0, lock1, holdover, reference
   task set_src(input int b, input logic bad);
      case (b)
         3: lk0 = ~bad;
         2: lk1 = ~bad;
         1: hold = bad;
         0: refp = ~bad;
         default: act[7-b] = ~bad;
      endcase
   endtask

   task complete_run;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge core_clk_i);
      #2 reset_i = 1'b0;
      rd_check(8'h88, 8'hab, "select reset");
      rd_check(8'h8a, 8'h00, "polarity reset");
      rd_check(8'h8c, 8'h00, "mask reset");
      rd_check(8'h90, 8'hff, "sticky reset");
      rd_check(8'h89, 8'h00, "unmapped");
      check1("pin a alarm", 1'b0, pa_o);
      check1("pin b both lock", 1'b1, pb_o);
      // enable low: a write must not land
      ce = 1'b0;
      wr(8'h8c, 8'hff);
      ce = 1'b1;
      rd_check(8'h8c, 8'h00, "mask frozen");
      wr(8'h8c, 8'hff);
      wr(8'h88, 8'hbd);
      for (int b = 0; b < 8; b++) begin
         set_src(b, 1'b1);
         step(2);
         rd_check(8'h94, ~(8'h01 << b), "momentary");
         set_src(b, 1'b0);
         step(3);
         check1("irq", 1'b1, irq);
         check1("pin a irq", 1'b1, pa_o);
         rd_check(8'h90, ~(8'h01 << b), "sticky");
         wr(8'h90, 8'h01 << b);
         step(3);
         check1("irq cleared", 1'b0, irq);
         rd_check(8'h90, 8'hff, "sticky cleared");
      end
      // masked event with the fault still present: clear must not win
      wr(8'h8c, 8'h00);
      lk0 = 1'b0;
      step(3);
      wr(8'h90, 8'h08);
      rd_check(8'h90, 8'hf7, "clear under fault");
      check1("masked irq", 1'b0, irq);
      lk0 = 1'b1;
      lk1 = 1'b0;
      act = 4'he;
      hold = 1'b1;
      for (int p = 0; p < 2; p++) begin
         wr(8'h8a, 8'(p));
         for (int k = 0; k < 5; k++) begin
            wr(8'h88, code[k]);
            step(2);
            check1("pin b oe", 1'b1, pb_oe);
            check1("pin b level", expv[k] ^ 1'(p), pb_o);
            check1("pin a alarm", ~1'(p), pa_o);
         end
         // pin A first-loop lock, pin B interrupt (all masked, so low)
         wr(8'h88, 8'hd8);
         step(2);
         check1("pin a lock0", ~1'(p), pa_o);
         check1("pin b irq", 1'(p), pb_o);
      end
      wr(8'h8a, 8'h00);
      idx = 2'b01;
      wr(8'h88, 8'haf);
      step(2);
      check1("index bit0", 1'b1, pa_o);
      check1("index bit1", 1'b0, pb_o);
      rd_check(8'h96, 8'h10, "selected index");
      wr(8'h88, 8'ha7);
      step(2);
      hen = 1'b1;
      ha = 1'b1;
      step(4);
      check1("pins released", 1'b0, pa_oe | pb_oe);
      check1("select valid", 1'b1, sel_v);
      check8("input select", 8'h01, {6'h00, sel});
      hb = 1'b1;
      step(4);
      check8("input select both", 8'h03, {6'h00, sel});
      wr(8'h88, 8'h21);
      hb = 1'b1;
      step(4);
      check1("force holdover", 1'b1, f_hold);
      check1("force mid", 1'b1, f_mid);
      rd_check(8'h96, 8'h90, "mid state");
      ha = 1'b0;
      step(4);
      check1("holdover release", 1'b0, f_hold);
      complete_run();
   end

   initial begin
      #(25 * 4000);
      bad_count++;
      complete_run();
   end
endmodule
`default_nettype wire
